// File: logic/ops_monitor.sv
`timescale 1ns/100ps
`include "ops_defines.svh"

module ops_monitor #(
  parameter int unsigned TICK_CYCLES = `OPS_TICK_CYCLES,
  parameter int unsigned INIT_TICKS  = `OPS_INIT_TICKS,
  parameter int unsigned WARN_TICKS  = `OPS_WARN_TICKS
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // AXI4-Lite write address
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Shared I/O side
  output logic                   sharedIoOwnerB,
  output logic                   sharedIoReset,
  output logic                   alarmRelay,
  // Interrupt requests toward the host channels
  output logic                   intPendingA,
  output logic                   intPendingB
);
  import ops_pkg::*;

  // Bus slave state
  logic [7:0]        awAddr;
  logic [31:0]       wData, wMask, wMasked, rdMux;
  logic [3:0]        wStrb;
  logic              wrFire, wrMapped, rdMapped, rdTake;

  // Block state
  logic              manual;
  ops_tstate_t       state, next_state;
  logic              testMode;
  logic [`OPS_TICK_W-1:0]   tickCnt;
  logic [`OPS_PERIOD_W-1:0] periodCnt;
  logic [1:0]        incurred, timeoutSt, attn, exc, devEnd, goAhead, warnCause;
  ops_cc_t           lastCc [2];
  logic [15:0]       statusWord [2];
  logic [31:0]       irqWord [2];
  logic [1:0]        pend;

  // Write path: address and data taken in either order, executed once both are held
  assign wrFire   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wrMapped = (awAddr[7:5] == 3'h0) & (awAddr[1:0] == 2'h0);
  assign rdMapped = (s_axi_araddr[7:5] == 3'h0) & (s_axi_araddr[1:0] == 2'h0);
  assign rdTake   = s_axi_arvalid & s_axi_arready;

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++)
    begin : g_lane
      assign wMask[gb*8 +: 8] = {8{wStrb[gb]}};
    end
  endgenerate
  assign wMasked = wData & wMask;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      awAddr        <= 8'h00;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        awAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrFire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Decoded register writes
  logic wrCtrl, wrCmd, wrIrqA, wrIrqB;
  assign wrCtrl = wrFire & (awAddr == `OPS_ADDR_CTRL);
  assign wrCmd  = wrFire & (awAddr == `OPS_ADDR_CMD);
  assign wrIrqA = wrFire & (awAddr == `OPS_ADDR_IRQ_A);
  assign wrIrqB = wrFire & (awAddr == `OPS_ADDR_IRQ_B);

  // Command decode; unwritten byte lanes count as zero
  logic [7:0] cmdCode;
  logic       issuerB, parityErr, issuerOwns, issuerPend, timerRuns, timerExpired;
  logic       isStart, isRestart, isReconnect, isDevReset;
  ops_cc_t    cmdCc;
  assign cmdCode      = wMasked[7:0];
  assign issuerB      = wMasked[`OPS_CMD_HOST_BIT];
  assign parityErr    = wMasked[`OPS_CMD_PARITY_BIT];
  assign issuerOwns   = (issuerB == sharedIoOwnerB);
  assign issuerPend   = pend[issuerB];
  assign isStart      = wrCmd & (cmdCode == `OPS_CMD_START);
  assign isRestart    = wrCmd & (cmdCode == `OPS_CMD_RESTART);
  assign isReconnect  = wrCmd & (cmdCode == `OPS_CMD_RECONNECT);
  assign isDevReset   = wrCmd & (cmdCode == `OPS_CMD_DEV_RESET);
  assign timerRuns    = (state == TM_INIT) | (state == TM_WARN);
  assign timerExpired = (state == TM_EXPIRED);

  // Nothing here makes the block busy, so code 1 arises from a pending interrupt only
  ops_cc_t startCc, reconnectCc;
  assign startCc = parityErr    ? `OPS_CC_PARITY :
                   issuerPend   ? `OPS_CC_BUSY :
                   manual       ? `OPS_CC_REJECT :
                   !issuerOwns  ? `OPS_CC_REJECT :
                   timerExpired ? `OPS_CC_INTERVENE :
                   `OPS_CC_OK;
  assign reconnectCc = parityErr    ? `OPS_CC_PARITY :
                       issuerPend   ? `OPS_CC_BUSY :
                       manual       ? `OPS_CC_REJECT :
                       issuerOwns   ? `OPS_CC_REJECT :
                       !timeoutSt[issuerB] ? `OPS_CC_REJECT :
                       `OPS_CC_OK;
  assign cmdCc = isStart ? startCc :
                 isReconnect ? reconnectCc :
                 (isRestart | isDevReset) ? `OPS_CC_OK :
                 `OPS_CC_REJECT;

  logic startOk, reconnectOk, reloadHit, warnZero;
  assign startOk     = isStart & (startCc == `OPS_CC_OK);
  assign reconnectOk = isReconnect & (reconnectCc == `OPS_CC_OK);
  // Reload serves restart and device reset alike; an expired timer is left alone
  assign reloadHit   = (isRestart | isDevReset) & issuerOwns & timerRuns;
  assign warnZero    = (WARN_TICKS == 0);

  // Fixed time base shared by both periods
  logic tick, initEnd, warnEnd, periodEnd, timeoutEv, testEndEv, warnEv;
  assign tick      = timerRuns & (tickCnt == `OPS_TICK_W'(TICK_CYCLES - 1));
  assign initEnd   = tick & (state == TM_INIT)
                     & (periodCnt == `OPS_PERIOD_W'(INIT_TICKS - 1)) & ~reloadHit;
  assign warnEnd   = tick & (state == TM_WARN)
                     & (periodCnt == `OPS_PERIOD_W'(WARN_TICKS - 1)) & ~reloadHit;
  assign periodEnd = warnEnd | (initEnd & warnZero);
  assign timeoutEv = periodEnd & ~testMode;
  assign testEndEv = periodEnd & testMode;
  assign warnEv    = initEnd & ~warnZero;

  always_comb
  begin
    next_state = state;
    unique case (state)
      TM_IDLE:    next_state = TM_IDLE;
      TM_INIT:    next_state = initEnd ? (warnZero ? TM_EXPIRED : TM_WARN) : TM_INIT;
      TM_WARN:    next_state = warnEnd ? TM_EXPIRED : TM_WARN;
      TM_EXPIRED: next_state = TM_EXPIRED;
    endcase
    if (periodEnd & testMode)
      next_state = TM_IDLE;
    if (startOk | reloadHit)
      next_state = TM_INIT;
    if (manual)
      next_state = TM_IDLE;
  end

  // The timer belongs to the owner of the moment, so a switch carries it along
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state     <= TM_IDLE;
      testMode  <= 1'b0;
      tickCnt   <= '0;
      periodCnt <= '0;
    end
    else
    begin
      state <= next_state;
      if (startOk)
        testMode <= wMasked[`OPS_IMM_TEST_BIT];
      if (startOk | reloadHit | initEnd | ~timerRuns)
      begin
        tickCnt   <= '0;
        periodCnt <= '0;
      end
      else if (tick)
      begin
        tickCnt   <= '0;
        periodCnt <= periodCnt + `OPS_PERIOD_W'(1);
      end
      else
        tickCnt <= tickCnt + `OPS_TICK_W'(1);
    end
  end

  // Control register and connection
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      manual         <= 1'(`OPS_CTRL_RESET >> `OPS_CTRL_MANUAL);
      sharedIoOwnerB <= 1'b0;
      sharedIoReset  <= 1'b0;
    end
    else
    begin
      sharedIoReset <= reconnectOk;
      if (wrCtrl & wStrb[0])
      begin
        manual         <= wData[`OPS_CTRL_MANUAL];
        sharedIoOwnerB <= wData[`OPS_CTRL_OWNER_B];
      end
      else if (reconnectOk)
        sharedIoOwnerB <= issuerB;
    end
  end

  // Per-host status, interrupt cause and condition code
  genvar gh;
  generate
    for (gh = 0; gh < 2; gh++)
    begin : g_host
      logic isOwner, isIssuer, wrIrq, clrAll, clrWarn;
      logic setAttn, setExc, setDevEnd, setGoAhead, setWarn;
      assign isOwner    = (sharedIoOwnerB == (gh == 1));
      assign isIssuer   = (issuerB == (gh == 1));
      assign wrIrq      = (gh == 1) ? wrIrqB : wrIrqA;
      assign setExc     = timeoutEv & isOwner;
      assign setGoAhead = timeoutEv & ~isOwner;
      assign setDevEnd  = testEndEv & isOwner;
      assign setWarn    = warnEv & isOwner;
      assign setAttn    = (initEnd & isOwner) | setGoAhead;
      assign clrAll     = isDevReset & isIssuer;
      assign clrWarn    = isRestart & isIssuer & ~warnZero;

      // A hardware event in the same cycle as a clear still lands
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          attn[gh]      <= 1'b0;
          exc[gh]       <= 1'b0;
          devEnd[gh]    <= 1'b0;
          goAhead[gh]   <= 1'b0;
          warnCause[gh] <= 1'b0;
        end
        else
        begin
          attn[gh]      <= (attn[gh] & ~(clrAll | (wrIrq & wMasked[`OPS_IRQ_ATTN]))) | setAttn;
          exc[gh]       <= (exc[gh] & ~(clrAll | (wrIrq & wMasked[`OPS_IRQ_EXC]))) | setExc;
          devEnd[gh]    <= (devEnd[gh] & ~(clrAll | (wrIrq & wMasked[`OPS_IRQ_DEVEND])))
                           | setDevEnd;
          goAhead[gh]   <= (goAhead[gh] & ~(clrAll | (wrIrq & wMasked[`OPS_IRQ_ATTN])))
                           | setGoAhead;
          warnCause[gh] <= (warnCause[gh]
                           & ~(clrAll | clrWarn | (wrIrq & wMasked[`OPS_IRQ_ATTN])))
                           | setWarn;
        end
      end

      // Manual mode holds both time-out bits off, even against a new event
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          incurred[gh]  <= 1'b0;
          timeoutSt[gh] <= 1'b0;
          lastCc[gh]    <= `OPS_CC_OK;
        end
        else
        begin
          incurred[gh]  <= ~manual & (incurred[gh] | setExc);
          timeoutSt[gh] <= ~manual & (timeoutSt[gh] | setGoAhead);
          if (wrCmd & isIssuer)
            lastCc[gh] <= cmdCc;
        end
      end

      assign pend[gh] = attn[gh] | exc[gh] | devEnd[gh];

      always_comb
      begin
        statusWord[gh]                    = 16'h0000;
        statusWord[gh][`OPS_ST_CONNECTED] = isOwner;
        statusWord[gh][`OPS_ST_MANUAL]    = manual;
        statusWord[gh][`OPS_ST_TIMEOUT]   = timeoutSt[gh];
        statusWord[gh][`OPS_ST_RUN]       = isOwner & timerRuns;
        statusWord[gh][`OPS_ST_INCURRED]  = incurred[gh];
        statusWord[gh][`OPS_ST_POLARITY]  = (gh == 0);
        irqWord[gh]                       = 32'h0000_0000;
        irqWord[gh][`OPS_CAUSE_GOAHEAD]   = goAhead[gh];
        irqWord[gh][`OPS_CAUSE_WARN]      = warnCause[gh];
        irqWord[gh][`OPS_IRQ_ATTN]        = attn[gh];
        irqWord[gh][`OPS_IRQ_EXC]         = exc[gh];
        irqWord[gh][`OPS_IRQ_DEVEND]      = devEnd[gh];
      end
    end
  endgenerate

  // Alarm and interrupt request pins
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      alarmRelay  <= 1'b0;
      intPendingA <= 1'b0;
      intPendingB <= 1'b0;
    end
    else
    begin
      alarmRelay  <= |incurred;
      intPendingA <= pend[0];
      intPendingB <= pend[1];
    end
  end

  // Read path
  always_comb
  begin
    rdMux = 32'h0000_0000;
    unique case (s_axi_araddr)
      `OPS_ADDR_CTRL:     rdMux = {30'h0, sharedIoOwnerB, manual};
      `OPS_ADDR_RESULT:   rdMux = {25'h0, lastCc[1], 1'b0, lastCc[0]};
      `OPS_ADDR_STATUS_A: rdMux = {16'h0000, statusWord[0]};
      `OPS_ADDR_STATUS_B: rdMux = {16'h0000, statusWord[1]};
      `OPS_ADDR_IRQ_A:    rdMux = irqWord[0];
      `OPS_ADDR_IRQ_B:    rdMux = irqWord[1];
      `OPS_ADDR_TIMER:    rdMux = {16'h0000, testMode, state, 1'b0, periodCnt};
      default:            rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end
    else if (rdTake)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdMux;
      s_axi_rresp   <= rdMapped ? 2'h0 : 2'h2;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

endmodule

// File: pkg/ops_defines.svh
`ifndef OPS_DEFINES_SVH
`define OPS_DEFINES_SVH

// Register byte addresses
`define OPS_ADDR_CTRL      8'h00
`define OPS_ADDR_CMD       8'h04
`define OPS_ADDR_RESULT    8'h08
`define OPS_ADDR_STATUS_A  8'h0c
`define OPS_ADDR_STATUS_B  8'h10
`define OPS_ADDR_IRQ_A     8'h14
`define OPS_ADDR_IRQ_B     8'h18
`define OPS_ADDR_TIMER     8'h1c

// Control register
`define OPS_CTRL_MANUAL    0
`define OPS_CTRL_OWNER_B   1
`define OPS_CTRL_RESET     32'h0000_0001

// Command register fields
`define OPS_CMD_HOST_BIT   8
`define OPS_CMD_PARITY_BIT 9
`define OPS_IMM_TEST_BIT   16

// Command codes
`define OPS_CMD_START      8'h6a
`define OPS_CMD_RESTART    8'h6c
`define OPS_CMD_RECONNECT  8'h6e
`define OPS_CMD_DEV_RESET  8'h6f

// Condition codes
`define OPS_CC_BUSY        3'h1
`define OPS_CC_REJECT      3'h3
`define OPS_CC_INTERVENE   3'h4
`define OPS_CC_PARITY      3'h5
`define OPS_CC_OK          3'h7

// Status word positions (host bit n sits at register bit 15-n)
`define OPS_ST_CONNECTED   15
`define OPS_ST_MANUAL      14
`define OPS_ST_TIMEOUT     13
`define OPS_ST_RUN         11
`define OPS_ST_INCURRED    10
`define OPS_ST_POLARITY    4

// Interrupt register: cause byte (host bit n at 7-n) and kinds
`define OPS_CAUSE_GOAHEAD  5
`define OPS_CAUSE_WARN     3
`define OPS_IRQ_ATTN       8
`define OPS_IRQ_EXC        9
`define OPS_IRQ_DEVEND     10

// Timing
`define OPS_CLK_HZ         20000000
`define OPS_TIME_BASE_US   1000
`define OPS_TICK_CYCLES    ((`OPS_CLK_HZ / 1000000) * `OPS_TIME_BASE_US)
`define OPS_INIT_TICKS     2000
`define OPS_WARN_TICKS     1000
`define OPS_TICK_W         15
`define OPS_PERIOD_W       12

`endif

// File: pkg/ops_pkg.sv
package ops_pkg;

  typedef enum logic [1:0] {
    TM_IDLE,
    TM_INIT,
    TM_WARN,
    TM_EXPIRED
  } ops_tstate_t;

  typedef logic [2:0] ops_cc_t;

endpackage

// File: testbench/ops_io_model.sv
`timescale 1ns/100ps
module ops_io_model (
  // Clock
  input  wire logic clock,
  // Shared I/O lines from the switch
  input  wire logic ownerB,
  input  wire logic ioReset,
  // Observation
  output int        resetCount
);
  logic prevOwner;
  initial resetCount = 0;
  // Only a reset that comes with a hand-over of the shared link is counted
  always @(posedge clock)
  begin
    prevOwner <= ownerB;
    if (ioReset && (ownerB != prevOwner))
      resetCount <= resetCount + 1;
  end
endmodule

// File: testbench/ops_monitor_sva.sv
`timescale 1ns/100ps
module ops_monitor_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Shared I/O side
  input wire logic        sharedIoOwnerB,
  input wire logic        sharedIoReset,
  input wire logic        alarmRelay,
  input wire logic        intPendingA,
  input wire logic        intPendingB
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");

  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");

  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("write response late");

  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after) else $error("read data late");

  property p_ready_low;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2];
  endproperty
  a_ready_low: assert property (p_ready_low) else $error("address ready reopened early");

  // Expiry posts to both hosts at once, so the alarm never rises alone
  property p_alarm;
    $rose(alarmRelay) |-> ##[0:1] (intPendingA && intPendingB);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm without both interrupts");

  property p_owner;
    $changed(sharedIoOwnerB) |-> !s_axi_awready;
  endproperty
  a_owner: assert property (p_owner) else $error("owner moved without a write");

  property p_io_pulse;
    sharedIoReset |=> !sharedIoReset;
  endproperty
  a_io_pulse: assert property (p_io_pulse) else $error("shared reset not a pulse");

  property p_rst_idle;
    $fell(rst) |-> s_axi_awready && !s_axi_bvalid && !alarmRelay && !sharedIoOwnerB;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("bad state after reset");
endmodule

bind ops_monitor ops_monitor_chk u_chk (
  .clock, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sharedIoOwnerB, .sharedIoReset,
  .alarmRelay, .intPendingA, .intPendingB
);

// File: testbench/tb.sv
`timescale 1ns/100ps
`include "ops_defines.svh"
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb;
  import ops_pkg::*;
  localparam int TK = 4;
  localparam int NI = 3;
  localparam int NW = 8;
  localparam int TEXP = (NI + NW + 2) * TK;
  logic        clock, rst;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        sharedIoOwnerB, sharedIoReset, alarmRelay, intPendingA, intPendingB;
  int          n_errors, n_checks, cycles, ioResets;
  logic [33:0] expQ[$], mskQ[$], monE, monM;
  string       nameQ[$], monN;
  logic [15:0] lfsrState;

  ops_monitor #(.TICK_CYCLES(TK), .INIT_TICKS(NI), .WARN_TICKS(NW)) dut (
    .clock, .rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sharedIoOwnerB, .sharedIoReset, .alarmRelay, .intPendingA, .intPendingB);
  ops_io_model partner (.clock, .ownerB(sharedIoOwnerB), .ioReset(sharedIoReset),
    .resetCount(ioResets));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Address and data are offered together and each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic gotA, gotW;
    gotA = 1'b0;
    gotW = 1'b0;
    @(posedge clock);
    lfsrState = lfsr(lfsrState);
    s_axi_awaddr <= a;
    s_axi_awprot <= lfsrState[2:0];
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    // Ready is sometimes held back so that the answer has to wait for it
    s_axi_bready <= lfsrState[4];
    while (!(gotA && gotW))
    begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready)
      begin
        gotA = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        gotW = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (!s_axi_bready)
    begin
      repeat (2) @(posedge clock);
      s_axi_bready <= 1'b1;
    end
    while (!(s_axi_bvalid && s_axi_bready))
      @(posedge clock);
    `CHK("bresp", 2'h0, s_axi_bresp)
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m,
                    input string nm);
    @(posedge clock);
    lfsrState = lfsr(lfsrState);
    expQ.push_back(e);
    mskQ.push_back(m);
    nameQ.push_back(nm);
    s_axi_araddr <= a;
    s_axi_arprot <= lfsrState[2:0];
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= lfsrState[3];
    do
      @(posedge clock);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    if (!s_axi_rready)
    begin
      @(posedge clock);
      s_axi_rready <= 1'b1;
    end
    while (!(s_axi_rvalid && s_axi_rready))
      @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdBit(input logic [7:0] a, input int i, input logic v, input string nm);
    rd(a, 34'(v) << i, 34'h1 << i, nm);
  endtask

  task automatic cmd(input logic [7:0] code, input logic host, input logic par,
                     input logic test, input logic [2:0] cc);
    wr(`OPS_ADDR_CMD, {15'h0, test, 6'h0, par, host, code});
    rd(`OPS_ADDR_RESULT, 34'(cc) << (host ? 4 : 0), 34'h7 << (host ? 4 : 0), "result");
  endtask

  // Oldest note is matched against each read answer as it appears
  always @(posedge clock)
    if (s_axi_rvalid && s_axi_rready && expQ.size() > 0)
    begin
      monE = expQ.pop_front();
      monM = mskQ.pop_front();
      monN = nameQ.pop_front();
      `CHK(monN, monE, {s_axi_rresp, s_axi_rdata} & monM)
    end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      summarize();
    end
  end

  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    {n_errors, n_checks, cycles} = '0;
    lfsrState = 16'h0015;
    rst = 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    wr(`OPS_ADDR_CTRL, 32'h0);
    rdBit(`OPS_ADDR_STATUS_A, `OPS_ST_CONNECTED, 1'b1, "connA");
    cmd(`OPS_CMD_START, 1'b1, 1'b0, 1'b0, `OPS_CC_REJECT);
    cmd(`OPS_CMD_START, 1'b0, 1'b1, 1'b0, `OPS_CC_PARITY);
    cmd(`OPS_CMD_START, 1'b0, 1'b0, 1'b0, `OPS_CC_OK);
    repeat ((NI + 1) * TK) @(posedge clock);
    rdBit(`OPS_ADDR_IRQ_A, `OPS_CAUSE_WARN, 1'b1, "warnCause");
    rdBit(`OPS_ADDR_IRQ_A, `OPS_IRQ_ATTN, 1'b1, "attnA");
    cmd(`OPS_CMD_RESTART, 1'b0, 1'b0, 1'b0, `OPS_CC_OK);
    rdBit(`OPS_ADDR_IRQ_A, `OPS_CAUSE_WARN, 1'b0, "warnClear");
    rd(`OPS_ADDR_TIMER, 34'h1 << 13, 34'h3 << 13, "stateInit");
    rdBit(`OPS_ADDR_STATUS_A, `OPS_ST_RUN, 1'b1, "runA");
    $display("Test restart done");
    repeat (TEXP) @(posedge clock);
    rd(`OPS_ADDR_TIMER, 34'h3 << 13, 34'h3 << 13, "stateExp");
    rdBit(`OPS_ADDR_STATUS_A, `OPS_ST_INCURRED, 1'b1, "incurredA");
    rdBit(`OPS_ADDR_STATUS_A, `OPS_ST_RUN, 1'b0, "runStop");
    rdBit(`OPS_ADDR_IRQ_A, `OPS_IRQ_EXC, 1'b1, "excA");
    rdBit(`OPS_ADDR_STATUS_B, `OPS_ST_TIMEOUT, 1'b1, "timeoutB");
    rd(`OPS_ADDR_IRQ_B, 34'h120, 34'h120, "goAheadB");
    `CHK("alarm", 1'b1, alarmRelay)
    `CHK("intA", 1'b1, intPendingA)
    `CHK("intB", 1'b1, intPendingB)
    cmd(`OPS_CMD_START, 1'b0, 1'b0, 1'b0, `OPS_CC_BUSY);
    wr(`OPS_ADDR_IRQ_A, 32'h700);
    cmd(`OPS_CMD_START, 1'b0, 1'b0, 1'b0, `OPS_CC_INTERVENE);
    cmd(`OPS_CMD_RESTART, 1'b0, 1'b0, 1'b0, `OPS_CC_OK);
    rd(`OPS_ADDR_TIMER, 34'h3 << 13, 34'h3 << 13, "stayExp");
    cmd(`OPS_CMD_RECONNECT, 1'b0, 1'b0, 1'b0, `OPS_CC_REJECT);
    cmd(`OPS_CMD_RECONNECT, 1'b1, 1'b0, 1'b0, `OPS_CC_BUSY);
    wr(`OPS_ADDR_IRQ_B, 32'h700);
    cmd(`OPS_CMD_RECONNECT, 1'b1, 1'b1, 1'b0, `OPS_CC_PARITY);
    cmd(`OPS_CMD_RECONNECT, 1'b1, 1'b0, 1'b0, `OPS_CC_OK);
    `CHK("ownerB", 1'b1, sharedIoOwnerB)
    `CHK("ioResets", 1, ioResets)
    rd(`OPS_ADDR_TIMER, 34'h3 << 13, 34'h3 << 13, "keepExp");
    $display("Test switchover done");
    wr(`OPS_ADDR_CTRL, 32'h1);
    rdBit(`OPS_ADDR_STATUS_A, `OPS_ST_INCURRED, 1'b0, "manualOff");
    `CHK("alarmManual", 1'b0, alarmRelay)
    cmd(`OPS_CMD_START, 1'b1, 1'b0, 1'b0, `OPS_CC_REJECT);
    wr(`OPS_ADDR_CTRL, 32'h2);
    cmd(`OPS_CMD_START, 1'b1, 1'b0, 1'b1, `OPS_CC_OK);
    cmd(`OPS_CMD_RESTART, 1'b1, 1'b0, 1'b0, `OPS_CC_OK);
    cmd(`OPS_CMD_DEV_RESET, 1'b1, 1'b0, 1'b0, `OPS_CC_OK);
    rd(`OPS_ADDR_TIMER, 34'ha000, 34'he000, "testRun");
    repeat (TEXP) @(posedge clock);
    rdBit(`OPS_ADDR_IRQ_B, `OPS_IRQ_DEVEND, 1'b1, "devEndB");
    rdBit(`OPS_ADDR_STATUS_B, `OPS_ST_INCURRED, 1'b0, "noIncurred");
    rdBit(`OPS_ADDR_STATUS_A, `OPS_ST_TIMEOUT, 1'b0, "noTimeout");
    rdBit(`OPS_ADDR_IRQ_A, `OPS_IRQ_ATTN, 1'b0, "noAttnA");
    rd(`OPS_ADDR_TIMER, 34'h0, 34'h6000, "testIdle");
    rd(8'h20, {2'b10, 32'h0}, {34{1'b1}}, "unmapped");
    $display("Test mode done");
    summarize();
  end
endmodule
